/* File: hdl/crs_top.sv */
// Purpose: cycle resize control and network warning flags of one station
// Assumes: APB slave, 32-bit data; peer events arrive as one-cycle pulses
// Notes: ownership range runs from the station address up by the width in the config register
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "crs_defines.svh"
module crs_top
#(
    parameter int STATIONS = 64
)
(
    // Clock and reset
    input  wire logic                   clock_i,
    input  wire logic                   nrst_i,
    // APB slave
    input  wire logic                   psel_i,
    input  wire logic                   penable_i,
    input  wire logic                   pwrite_i,
    input  wire logic [7:0]             paddr_i,
    input  wire logic [31:0]            pwdata_i,
    output logic      [31:0]            prdata_o,
    output logic                        pready_o,
    output logic                        pslverr_o,
    // Station phase and identity
    input  wire logic                   run_phase_i,
    input  wire logic                   break_phase_i,
    input  wire logic                   public_frame_i,
    input  wire logic [5:0]             station_address_i,
    // Network events from the receiver
    input  wire logic                   peer_req_i,
    input  wire logic [5:0]             peer_value_i,
    input  wire logic [5:0]             peer_addr_i,
    input  wire logic                   peer_end_i,
    input  wire logic                   break_rx_i,
    input  wire logic                   jammer_i,
    input  wire logic                   out_of_cycle_stop_i,
    input  wire logic [5:0]             stop_addr_i,
    input  wire logic [STATIONS-1:0]    link_update_i,
    input  wire logic [STATIONS-1:0]    member_update_i,
    // Network requests to the transmitter, active limit and its update strobe
    output logic                        own_req_o,
    output logic [5:0]                  own_value_o,
    output logic                        own_end_o,
    output logic                        break_tx_o,
    output logic [5:0]                  last_slot_index_o,
    output logic                        limit_updated_o
);

    crs_req_if                  rq ();

    crs_pkg::crs_slot_t         pending_q;
    crs_pkg::crs_slot_t         active_q;
    logic                       mem_mode_q;
    logic [5:0]                 own_width_q;
    logic [STATIONS-1:0]        link_q;
    logic [STATIONS-1:0]        member_q;
    logic [31:0]                prdata_q;
    logic                       pready_q;
    logic                       pslverr_q;
    logic                       own_req_q;
    logic                       own_end_q;
    logic                       break_tx_q;
    logic                       updated_q;

    logic                       wr_cycle;
    logic                       rd_cycle;
    logic                       wr_pending;
    logic                       wr_status;
    logic                       wr_config;
    logic [6:0]                 own_top;
    logic                       value_ok;
    logic                       accept;
    logic                       ending;
    logic                       collision_flag;
    logic                       jammer_flag;
    logic                       break_seen_flag;

    // Access phase; answered in the same cycle, so pready rises a cycle later
    assign wr_cycle   = psel_i && penable_i && pwrite_i && !pready_q;
    assign rd_cycle   = psel_i && penable_i && !pwrite_i && !pready_q;
    assign wr_pending = wr_cycle && (paddr_i == `CRS_OFF_PENDING);
    assign wr_status  = wr_cycle && (paddr_i == `CRS_OFF_STATUS);
    assign wr_config  = wr_cycle && (paddr_i == `CRS_OFF_CONFIG);

    // Highest address in the claimed range
    assign own_top  = {1'b0, station_address_i} + {1'b0, own_width_q};
    assign value_ok = ({1'b0, pwdata_i[5:0]} >= own_top);
    assign ending   = wr_pending && (pwdata_i[5:0] == `CRS_SLOT_ZERO)
                      && run_phase_i && mem_mode_q;
    assign accept   = wr_pending && run_phase_i && mem_mode_q
                      && value_ok && (pwdata_i[5:0] != `CRS_SLOT_ZERO);

    // Arbiter request wiring
    assign rq.own_req    = accept;
    assign rq.own_value  = accept ? pwdata_i[5:0] : pending_q;
    assign rq.own_addr   = station_address_i;
    assign rq.own_end    = ending;
    assign rq.peer_req   = peer_req_i && run_phase_i;
    assign rq.peer_value = peer_value_i;
    assign rq.peer_addr  = peer_addr_i;
    assign rq.peer_end   = peer_end_i && run_phase_i;

    crs_arbiter u_arb
    (
        .clock_i (clock_i),
        .nrst_i  (nrst_i),
        .req     (rq.arb)
    );

    // Warning flags: write one clears, write zero leaves alone
    crs_flag u_collision
    (
        .clock_i (clock_i),
        .nrst_i  (nrst_i),
        .set_i   (rq.collide),
        .clear_i (wr_status && pwdata_i[`CRS_ST_COLLISION]),
        .flag_o  (collision_flag)
    );

    crs_flag u_jammer
    (
        .clock_i (clock_i),
        .nrst_i  (nrst_i),
        .set_i   (jammer_i),
        .clear_i (wr_status && pwdata_i[`CRS_ST_JAMMER]),
        .flag_o  (jammer_flag)
    );

    crs_flag u_break
    (
        .clock_i (clock_i),
        .nrst_i  (nrst_i),
        .set_i   (break_rx_i && run_phase_i),
        .clear_i (wr_status && pwdata_i[`CRS_ST_BREAK]),
        .flag_o  (break_seen_flag)
    );

    // Pending value: only accepted values or zero are stored
    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
            pending_q <= `CRS_SLOT_ZERO;
        else if (accept || ending)
            pending_q <= pwdata_i[5:0];
    end

    // Active limit follows whichever resize the arbiter grants
    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            active_q  <= `CRS_SLOT_MAX;
            updated_q <= 1'b0;
        end
        else
        begin
            updated_q <= 1'b0;
            if (rq.adopt)
            begin
                active_q  <= rq.adopt_value;
                updated_q <= (rq.adopt_value != active_q);
            end
        end
    end

    // Station configuration
    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            mem_mode_q  <= 1'b1;
            own_width_q <= `CRS_SLOT_ZERO;
        end
        else if (wr_config)
        begin
            mem_mode_q  <= pwdata_i[`CRS_CFG_MEM_MODE];
            own_width_q <= pwdata_i[`CRS_CFG_OWN_LSB +: `CRS_SLOT_W];
        end
    end

    // Link and member flags; an out-of-cycle stop drops that station
    generate
        for (genvar i = 0; i < STATIONS; i++)
        begin : g_stn
            always_ff @(posedge clock_i)
            begin
                if (!nrst_i)
                begin
                    link_q[i]   <= 1'b0;
                    member_q[i] <= 1'b0;
                end
                else if (out_of_cycle_stop_i && stop_addr_i == 6'(i))
                begin
                    link_q[i]   <= 1'b0;
                    member_q[i] <= 1'b0;
                end
                else
                begin
                    link_q[i]   <= link_update_i[i];
                    member_q[i] <= member_update_i[i];
                end
            end
        end
    endgenerate

    // Network side strobes
    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            own_req_q  <= 1'b0;
            own_end_q  <= 1'b0;
            break_tx_q <= 1'b0;
        end
        else
        begin
            own_req_q  <= rq.adopt && (accept ? !rq.collide : !rq.peer_req);
            own_end_q  <= ending && rq.owner;
            break_tx_q <= break_phase_i && public_frame_i;
        end
    end

    // APB answer
    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= psel_i && penable_i && !pready_q;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            if (rd_cycle)
            begin
                if (paddr_i == `CRS_OFF_PENDING)
                    prdata_q <= {26'h0, pending_q};
                else if (paddr_i == `CRS_OFF_ACTIVE)
                    prdata_q <= {26'h0, active_q};
                else if (paddr_i == `CRS_OFF_STATUS)
                    prdata_q <= {21'h0, break_seen_flag, jammer_flag,
                                 collision_flag, 8'h00};
                else if (paddr_i == `CRS_OFF_CONTROL)
                    prdata_q <= {22'h0, run_phase_i, 9'h000};
                else if (paddr_i == `CRS_OFF_CONFIG)
                    prdata_q <= {18'h0, own_width_q, 7'h00, mem_mode_q};
                else if (paddr_i == `CRS_OFF_LINK)
                    prdata_q <= link_q[31:0];
                else if (paddr_i == `CRS_OFF_MEMBER)
                    prdata_q <= member_q[31:0];
                else if (paddr_i == `CRS_OFF_OOC)
                    prdata_q <= link_q[STATIONS-1:32];
                else
                    pslverr_q <= 1'b1;
            end
            else if (wr_cycle && !(wr_pending || wr_status || wr_config))
                pslverr_q <= 1'b1;
        end
    end

    assign prdata_o          = prdata_q;
    assign pready_o          = pready_q;
    assign pslverr_o         = pslverr_q;
    assign own_req_o         = own_req_q;
    assign own_value_o       = pending_q;
    assign own_end_o         = own_end_q;
    assign break_tx_o        = break_tx_q;
    assign last_slot_index_o = active_q;
    assign limit_updated_o   = updated_q;

endmodule

/* File: inc/crs_defines.svh */
// Purpose: offsets, field positions and reset values of the resize block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: included by the top, arbiter, checker and test files; the flag, package and interface files do not include it
`ifndef CRS_DEFINES_SVH
`define CRS_DEFINES_SVH

`define CRS_ADDR_W          8
`define CRS_OFF_PENDING     8'h00
`define CRS_OFF_ACTIVE      8'h04
`define CRS_OFF_STATUS      8'h08
`define CRS_OFF_CONTROL     8'h0c
`define CRS_OFF_CONFIG      8'h10
`define CRS_OFF_LINK        8'h14
`define CRS_OFF_MEMBER      8'h18
`define CRS_OFF_OOC         8'h1c

`define CRS_SLOT_W          6
`define CRS_SLOT_MAX        6'h3f
`define CRS_SLOT_ZERO       6'h00

`define CRS_ST_COLLISION    8
`define CRS_ST_JAMMER       9
`define CRS_ST_BREAK        10
`define CRS_CTL_RUN         9
`define CRS_CFG_MEM_MODE    0
`define CRS_CFG_OWN_LSB     8

`endif

/* File: inc/crs_pkg.sv */
// Purpose: shared types of the resize block
// Assumes: nothing
// Notes: arbiter states live here so every file sees one definition
package crs_pkg;

    typedef logic [5:0] crs_slot_t;

    typedef enum logic [1:0]
    {
        CRS_ARB_IDLE,
        CRS_ARB_OWNER,
        CRS_ARB_LOSER
    } crs_arb_e;

endpackage

/* File: inc/crs_req_if.sv */
// Purpose: carries resize requests between the top and the arbiter
// Assumes: one clock domain
// Notes: peer request seen on the network in the current cycle
`timescale 1ns/1ps
interface crs_req_if;
    logic                   own_req;
    crs_pkg::crs_slot_t     own_value;
    crs_pkg::crs_slot_t     own_addr;
    logic                   own_end;
    logic                   peer_req;
    crs_pkg::crs_slot_t     peer_value;
    crs_pkg::crs_slot_t     peer_addr;
    logic                   peer_end;
    logic                   adopt;
    crs_pkg::crs_slot_t     adopt_value;
    logic                   collide;
    logic                   owner;

    modport top
    (
        output own_req, own_value, own_addr, own_end,
        output peer_req, peer_value, peer_addr, peer_end,
        input  adopt, adopt_value, collide, owner
    );
    modport arb
    (
        input  own_req, own_value, own_addr, own_end,
        input  peer_req, peer_value, peer_addr, peer_end,
        output adopt, adopt_value, collide, owner
    );
endinterface

/* File: hdl/crs_arbiter.sv */
// Purpose: decides which station's resize owns the network
// Assumes: peer requests and ends arrive as one-cycle pulses
// Notes: an own resize beats later peers once granted; a lone peer resize is not held; ties go to the lower station address
`timescale 1ns/1ps
`include "crs_defines.svh"
module crs_arbiter
(
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       nrst_i,
    // Requests
    crs_req_if.arb          req
);

    crs_pkg::crs_arb_e      state_q;
    crs_pkg::crs_slot_t     holder_q;
    crs_pkg::crs_slot_t     held_value_q;
    logic                   own_wins;

    // Own request beats a coincident peer only with the lower address
    assign own_wins = req.own_req && (!req.peer_req || req.own_addr < req.peer_addr);

    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            state_q      <= crs_pkg::CRS_ARB_IDLE;
            holder_q     <= `CRS_SLOT_ZERO;
            held_value_q <= `CRS_SLOT_ZERO;
        end
        else
        begin
            case (state_q)
                crs_pkg::CRS_ARB_IDLE:
                begin
                    if (own_wins)
                    begin
                        state_q      <= crs_pkg::CRS_ARB_OWNER;
                        holder_q     <= req.own_addr;
                        held_value_q <= req.own_value;
                    end
                    else if (req.peer_req)
                    begin
                        state_q      <= req.own_req ? crs_pkg::CRS_ARB_LOSER
                                                    : crs_pkg::CRS_ARB_IDLE;
                        holder_q     <= req.peer_addr;
                        held_value_q <= req.peer_value;
                    end
                end
                crs_pkg::CRS_ARB_OWNER:
                begin
                    if (req.own_end)
                        state_q <= crs_pkg::CRS_ARB_IDLE;
                end
                crs_pkg::CRS_ARB_LOSER:
                begin
                    if (req.own_end)
                        state_q <= crs_pkg::CRS_ARB_IDLE;
                    else if (req.peer_end && req.peer_addr == holder_q)
                    begin
                        state_q      <= crs_pkg::CRS_ARB_OWNER;
                        holder_q     <= req.own_addr;
                        held_value_q <= req.own_value;
                    end
                end
                default:
                    state_q <= crs_pkg::CRS_ARB_IDLE;
            endcase
        end
    end

    always_comb
    begin
        req.adopt       = 1'b0;
        req.adopt_value = req.own_value;
        req.collide     = 1'b0;
        req.owner       = (state_q == crs_pkg::CRS_ARB_OWNER);
        case (state_q)
            crs_pkg::CRS_ARB_IDLE:
            begin
                if (own_wins)
                begin
                    req.adopt = 1'b1;
                end
                else if (req.peer_req)
                begin
                    req.adopt       = 1'b1;
                    req.adopt_value = req.peer_value;
                    req.collide     = req.own_req;
                end
            end
            crs_pkg::CRS_ARB_OWNER:
            begin
                // A later peer request is not adopted but raises a collision
                req.collide = req.peer_req;
            end
            crs_pkg::CRS_ARB_LOSER:
            begin
                if (!req.own_end && req.peer_end && req.peer_addr == holder_q)
                    req.adopt = 1'b1;
                req.collide = req.own_req;
            end
            default:
            begin
                req.adopt = 1'b0;
            end
        endcase
    end

endmodule

/* File: hdl/crs_flag.sv */
// Purpose: sticky warning flag, set by hardware, cleared by writing one
// Assumes: set and clear are single-cycle strobes
// Notes: set wins over a clear in the same cycle
`timescale 1ns/1ps
module crs_flag
(
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       nrst_i,
    // Control
    input  wire logic       set_i,
    input  wire logic       clear_i,
    output logic            flag_o
);

    logic                   flag_q;

    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
            flag_q <= 1'b0;
        else if (set_i)
            flag_q <= 1'b1;
        else if (clear_i)
            flag_q <= 1'b0;
    end

    assign flag_o = flag_q;

endmodule

/* File: sim/crs_top_checker.sv */
// Purpose: port-level checks of the resize block
// Assumes: one clock, synchronous active-low reset
// Notes: bound into every crs_top instance
`timescale 1ns/1ps
`include "crs_defines.svh"
module crs_top_checker
#(
    parameter int STATIONS = 64
)
(
    // Clock and reset
    input wire logic        clock_i,
    input wire logic        nrst_i,
    // APB
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // Station and network
    input wire logic        run_phase_i,
    input wire logic        break_phase_i,
    input wire logic        public_frame_i,
    input wire logic [5:0]  station_address_i,
    input wire logic        peer_req_i,
    input wire logic        peer_end_i,
    input wire logic        own_req_o,
    input wire logic [5:0]  own_value_o,
    input wire logic        break_tx_o,
    input wire logic [5:0]  last_slot_index_o
);
    logic take;
    logic pend_wr;
    assign take    = psel_i && penable_i && !pready_o;
    assign pend_wr = take && pwrite_i && paddr_i == `CRS_OFF_PENDING;

    default clocking @(posedge clock_i);
    endclocking
    default disable iff (!nrst_i);

    a_reset_limit: assert property (!$past(nrst_i) |-> last_slot_index_o == 6'h3f)
        else $error("limit not at maximum after reset");
    a_apb_answer: assert property (take |=> pready_o ##1 !pready_o)
        else $error("apb answer not a single pulse one cycle later");
    a_err_ready: assert property (pslverr_o |-> pready_o)
        else $error("slave error without ready");
    a_break_send: assert property (1 |=> break_tx_o == $past(break_phase_i && public_frame_i))
        else $error("break transmit does not follow break phase in public frame");
    a_req_value: assert property (own_req_o |-> last_slot_index_o == own_value_o)
        else $error("granted request and limit disagree");
    a_req_pulse: assert property (own_req_o |=> !own_req_o)
        else $error("own request longer than one cycle");
    a_run_guard: assert property (pend_wr && !run_phase_i |=> !own_req_o)
        else $error("resize started outside run phase");
    a_range_guard: assert property (pend_wr && !peer_end_i && pwdata_i[5:0] != 6'h00
        && pwdata_i[5:0] < station_address_i |=> !own_req_o)
        else $error("resize below own range started");
    a_peer_guard: assert property (!run_phase_i [*2] ##0 peer_req_i
        |=> $stable(last_slot_index_o))
        else $error("peer resize adopted outside run phase");

    c_own_req: cover property (own_req_o);
    c_break_tx: cover property (break_tx_o);
    c_slv_err: cover property (pslverr_o);
endmodule

bind crs_top crs_top_checker #(.STATIONS(STATIONS)) chk_u
(
    .clock_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pready_o, .pslverr_o, .run_phase_i, .break_phase_i, .public_frame_i,
    .station_address_i, .peer_req_i, .peer_end_i, .own_req_o, .own_value_o,
    .break_tx_o, .last_slot_index_o
);

/* File: sim/crs_peer_model.sv */
// Purpose: peer stations seen through the network receiver
// Assumes: events are one-cycle pulses
// Notes: address and value lines show inverted junk outside a pulse
`timescale 1ns/1ps
module crs_peer_model
(
    // Clock
    input  wire logic  clock_i,
    // Events toward the station
    output logic       peer_req_o,
    output logic [5:0] peer_value_o,
    output logic [5:0] peer_addr_o,
    output logic       peer_end_o,
    output logic       break_rx_o,
    output logic       jammer_o
);
    initial
    begin
        {peer_req_o, peer_end_o, break_rx_o, jammer_o} = 4'h0;
        peer_value_o = 6'h00;
        peer_addr_o  = 6'h00;
    end

    // Kind 0 resize, 1 end of resize, 2 break packet, 3 jammer
    task automatic send(input int kind, input logic [5:0] addr, input logic [5:0] value);
        @(posedge clock_i);
        peer_req_o   <= (kind == 0);
        peer_end_o   <= (kind == 1);
        break_rx_o   <= (kind == 2);
        jammer_o     <= (kind == 3);
        peer_addr_o  <= addr;
        peer_value_o <= value;
        @(posedge clock_i);
        {peer_req_o, peer_end_o, break_rx_o, jammer_o} <= 4'h0;
        peer_addr_o  <= ~addr;
        peer_value_o <= ~value;
    endtask
endmodule

/* File: sim/cycle_resize_and_net_alerts_test.sv */
// Purpose: self-checking bench of the resize block
// Assumes: station address 4, peers driven by crs_peer_model
// Notes: each scenario starts from a fresh reset
`timescale 1ns/1ps
`include "crs_defines.svh"
module cycle_resize_and_net_alerts_test;
    logic        clock_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err_q;
    logic        run_phase_i, break_phase_i, public_frame_i, own_req_o, own_end_o;
    logic        peer_req_i, peer_end_i, break_rx_i, jammer_i, break_tx_o, limit_updated_o;
    logic        out_of_cycle_stop_i;
    logic [7:0]  paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd_q;
    logic [5:0]  peer_value_i, peer_addr_i, station_address_i, own_value_o, last_slot_index_o;
    int          bad_count, total_checks, req_n, end_n, upd_n;

    crs_top dut_u
    (
        .clock_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .run_phase_i, .break_phase_i,
        .public_frame_i, .station_address_i, .peer_req_i, .peer_value_i,
        .peer_addr_i, .peer_end_i, .break_rx_i, .jammer_i,
        .out_of_cycle_stop_i, .stop_addr_i(6'h05), .link_update_i('1),
        .member_update_i('1), .own_req_o, .own_value_o, .own_end_o, .break_tx_o,
        .last_slot_index_o, .limit_updated_o
    );

    crs_peer_model peer_u
    (
        .clock_i, .peer_req_o(peer_req_i), .peer_value_o(peer_value_i),
        .peer_addr_o(peer_addr_i), .peer_end_o(peer_end_i),
        .break_rx_o(break_rx_i), .jammer_o(jammer_i)
    );

    always #5 clock_i = ~clock_i;

    // Pulse counters so one-cycle outputs are never missed
    always @(posedge clock_i)
    begin
        if (own_req_o === 1'b1) req_n++;
        if (own_end_o === 1'b1) end_n++;
        if (limit_updated_o === 1'b1) upd_n++;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        @(posedge clock_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= wr;
        paddr_i   <= addr;
        pwdata_i  <= data;
        @(posedge clock_i);
        penable_i <= 1'b1;
        do @(posedge clock_i); while (pready_o !== 1'b1);
        rd_q = prdata_o;
        err_q = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] addr);
        apb(1'b0, addr, 32'h0);
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        apb(1'b1, addr, data);
    endtask

    task automatic settle();
        repeat (3) @(posedge clock_i);
    endtask

    task automatic do_reset();
        nrst_i <= 1'b0;
        repeat (16) @(posedge clock_i);
        req_n = 0;
        end_n = 0;
        upd_n = 0;
        nrst_i <= 1'b1;
    endtask

    task automatic t_regs();
        do_reset();
        check(32'(last_slot_index_o), 32'h3f);
        rd(`CRS_OFF_ACTIVE);
        check(rd_q, 32'h3f);
        rd(`CRS_OFF_CONFIG);
        check(rd_q, 32'h1);
        rd(`CRS_OFF_STATUS);
        check(rd_q, 32'h0);
        rd(8'h40);
        check(32'(err_q), 32'h1);
        out_of_cycle_stop_i <= 1'b1;
        rd(`CRS_OFF_LINK);
        check(rd_q, 32'hffff_ffdf);
        out_of_cycle_stop_i <= 1'b0;
        rd(`CRS_OFF_LINK);
        check(rd_q, 32'hffff_ffff);
        $display("test regs done");
    endtask

    task automatic t_refuse();
        do_reset();
        run_phase_i <= 1'b0;
        wr(`CRS_OFF_PENDING, 32'h20);
        peer_u.send(0, 6'h01, 6'h08);
        rd(`CRS_OFF_PENDING);
        check(rd_q, 32'h0);
        check(32'(last_slot_index_o), 32'h3f);
        run_phase_i <= 1'b1;
        rd(`CRS_OFF_CONTROL);
        check(rd_q, 32'h200);
        wr(`CRS_OFF_CONFIG, 32'h201);
        wr(`CRS_OFF_PENDING, 32'h3);
        wr(`CRS_OFF_PENDING, 32'h5);
        rd(`CRS_OFF_PENDING);
        check(rd_q, 32'h0);
        wr(`CRS_OFF_PENDING, 32'h6);
        rd(`CRS_OFF_PENDING);
        check(rd_q, 32'h6);
        check(32'(last_slot_index_o), 32'h6);
        wr(`CRS_OFF_CONFIG, 32'h200);
        wr(`CRS_OFF_PENDING, 32'h20);
        rd(`CRS_OFF_PENDING);
        check(rd_q, 32'h6);
        $display("test refuse done");
    endtask

    task automatic t_own();
        do_reset();
        wr(`CRS_OFF_PENDING, 32'h10);
        settle();
        check(32'(last_slot_index_o), 32'h10);
        check(32'(req_n), 32'h1);
        peer_u.send(0, 6'h01, 6'h30);
        settle();
        check(32'(last_slot_index_o), 32'h10);
        rd(`CRS_OFF_STATUS);
        check(rd_q, 32'h100);
        wr(`CRS_OFF_STATUS, 32'h0);
        rd(`CRS_OFF_STATUS);
        check(rd_q, 32'h100);
        wr(`CRS_OFF_STATUS, 32'h100);
        rd(`CRS_OFF_STATUS);
        check(rd_q, 32'h0);
        wr(`CRS_OFF_PENDING, 32'h0);
        settle();
        check(32'(end_n), 32'h1);
        $display("test own done");
    endtask

    task automatic t_adopt();
        do_reset();
        peer_u.send(0, 6'h08, 6'h20);
        settle();
        check(32'(last_slot_index_o), 32'h20);
        check(32'(upd_n), 32'h1);
        check(32'(req_n), 32'h0);
        $display("test adopt done");
    endtask

    task automatic t_tie(input logic [5:0] addr, input logic win);
        do_reset();
        fork
            wr(`CRS_OFF_PENDING, 32'h30);
            begin
                @(posedge clock_i);
                peer_u.send(0, addr, 6'h18);
            end
        join
        settle();
        check(32'(last_slot_index_o), win ? 32'h30 : 32'h18);
        rd(`CRS_OFF_STATUS);
        check(rd_q, win ? 32'h0 : 32'h100);
        if (!win)
        begin
            peer_u.send(1, addr, 6'h00);
            settle();
            check(32'(last_slot_index_o), 32'h30);
            check(32'(req_n), 32'h1);
        end
        $display("test tie done");
    endtask

    task automatic t_flags();
        do_reset();
        run_phase_i <= 1'b0;
        peer_u.send(2, 6'h00, 6'h00);
        run_phase_i <= 1'b1;
        rd(`CRS_OFF_STATUS);
        check(rd_q, 32'h0);
        peer_u.send(2, 6'h00, 6'h00);
        peer_u.send(3, 6'h00, 6'h00);
        rd(`CRS_OFF_STATUS);
        check(rd_q, 32'h600);
        wr(`CRS_OFF_PENDING, 32'h3f);
        rd(`CRS_OFF_PENDING);
        check(rd_q, 32'h3f);
        wr(`CRS_OFF_STATUS, 32'h600);
        rd(`CRS_OFF_STATUS);
        check(rd_q, 32'h0);
        peer_u.send(3, 6'h00, 6'h00);
        rd(`CRS_OFF_STATUS);
        check(rd_q, 32'h200);
        break_phase_i  <= 1'b1;
        public_frame_i <= 1'b1;
        settle();
        check(32'(break_tx_o), 32'h1);
        public_frame_i <= 1'b0;
        settle();
        check(32'(break_tx_o), 32'h0);
        $display("test flags done");
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        #100us;
        bad_count++;
        end_sim();
    end

    initial
    begin
        {clock_i, nrst_i, psel_i, penable_i, pwrite_i} = 5'h0;
        {break_phase_i, public_frame_i, out_of_cycle_stop_i} = 3'h0;
        run_phase_i = 1'b1;
        station_address_i = 6'h04;
        paddr_i = 8'h00;
        pwdata_i = 32'h0;
        t_regs();
        t_refuse();
        t_own();
        t_adopt();
        t_tie(6'h02, 1'b0);
        t_tie(6'h06, 1'b1);
        t_flags();
        end_sim();
    end
endmodule
